// ==== bench/dbl_assertions.sv ====
// Timing checks on the wires between the controller end and the memory end.
`timescale 1ns/100ps
`default_nettype none
module dbl_assertions
  import dbl_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic [2:0]        mr_sel,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              dq_ctl_oe,
  input wire logic [4:0]        added_delay,
  input wire logic              dq_dev_oe,
  input wire logic              dqs_dev_oe
);
  logic [ADDR_W-1:0] mode_r;
  wire [2:0] cmd = {ras_n, cas_n, we_n};
  wire mode_set_command = cmd == CMD_MRS && mr_sel == MR_SEL_FIRST;
  wire rd = cmd == CMD_RD;
  wire cl9 = {mode_r[12], mode_r[6:4], mode_r[2]} == 5'h00;
  wire bl8 = cl9 && mode_r[1:0] == BL_FIX8;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) mode_r <= MODE_RST;
    else if (mode_set_command) mode_r <= addr;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_rd8; dq_dev_oe [*8] ##1 !dq_dev_oe; endsequence
  sequence s_rd4; dq_dev_oe [*4] ##1 !dq_dev_oe [*4]; endsequence
  property p_rd8; rd && bl8 && added_delay == 5'h00 |-> ##10 s_rd8; endproperty
  a_rd8: assert property (p_rd8) else $error("read burst timing");
  property p_rd_al; rd && bl8 && added_delay == 5'h02 |-> ##12 s_rd8; endproperty
  a_rd_al: assert property (p_rd_al) else $error("added delay timing");
  property p_chop; rd && cl9 && added_delay == 5'h00 && mode_r[1:0] == BL_FIX4 |-> ##10 s_rd4;
  endproperty
  a_chop: assert property (p_chop) else $error("chopped read slots");
  property p_wr8; cmd == CMD_WR && bl8 && added_delay == 5'h00 |-> ##10 dq_ctl_oe [*8];
  endproperty
  a_wr8: assert property (p_wr8) else $error("write beat timing");
  property p_tm; mode_set_command |-> !addr[MR_TM_BIT]; endproperty
  a_tm: assert property (p_tm) else $error("test bit set");
  property p_strobe; dq_dev_oe == dqs_dev_oe; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe enable split");
  property p_mrs; mode_set_command |=> cmd == CMD_NOP; endproperty
  a_mrs: assert property (p_mrs) else $error("mode set not one cycle");
  property p_lock; mode_set_command && addr[MR_DLL_BIT] |-> ##1 !rd [*8]; endproperty
  a_lock: assert property (p_lock) else $error("read during lock");
endmodule
`default_nettype wire

// ==== bench/dram_burst_latency_mode_zero_test.sv ====
// Bench for both link ends driven over the register bus.
`timescale 1ns/100ps
`default_nettype none
module dram_burst_latency_mode_zero_test
  import dbl_pkg::*;
;
  logic core_clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic awr, wr, bv, arr, rv, lk, bk, rk;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdt, rdat;
  logic [1:0] bre, rre, rsp;
  logic [ADDR_W-1:0] mi;
  int n_fail = 0, num_checks = 0, cyc = 0;
  bit ta, tw;
  dbl_if bus_i();
  dbl_mem_end #(.DLLK_CYC(16)) u_dbl_mem_end (.core_clk(core_clk), .rst(rst), .bus(bus_i),
    .bank_ready(bk), .read_ready(rk), .dll_locked(lk), .mode_image(mi));
  dbl_ctl_end #(.DLLK_CYC(16)) u_dbl_ctl_end (.core_clk(core_clk), .rst(rst), .bus(bus_i),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_bresp(bre), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdt),
    .s_axi_rresp(rre));
  dbl_assertions u_chk (.core_clk(core_clk), .rst(rst), .ras_n(bus_i.ras_n),
    .cas_n(bus_i.cas_n), .we_n(bus_i.we_n), .mr_sel(bus_i.mr_sel), .addr(bus_i.addr),
    .dq_ctl_oe(bus_i.dq_ctl_oe), .added_delay(bus_i.added_delay),
    .dq_dev_oe(bus_i.dq_dev_oe), .dqs_dev_oe(bus_i.dqs_dev_oe));
  initial forever #5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Ready is looked at before the edge, so the release lands right after it.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {awv, wv, br, awa, wd} <= {3'h7, a, d};
    {ta, tw} = 2'h0;
    while (!(ta && tw)) begin
      @(negedge core_clk);
      {ta, tw} = {ta | awr, tw | wr};
      @(posedge core_clk);
      {awv, wv} <= {awv & !ta, wv & !tw};
    end
    do begin @(negedge core_clk); rsp = bre; ta = bv; @(posedge core_clk); end while (!ta);
    br <= 0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge core_clk);
    {arv, rr, ara} <= {2'h3, a};
    do begin @(negedge core_clk); ta = arr; @(posedge core_clk); end while (!ta);
    arv <= 0;
    do begin @(negedge core_clk); {ta, rsp, rdat} = {rv, rre, rdt}; @(posedge core_clk);
    end while (!ta);
    rr <= 0;
  endtask
  task automatic op(input logic [31:0] c);
    axw(REG_CMD, c);
    do axr(REG_STAT); while (rdat[1:0] !== 2'h0);
  endtask
  task automatic rd2(input logic [31:0] c, input logic [31:0] lo, input logic [31:0] hi);
    op(c);
    axr(REG_RLO);
    chk(rdat, lo);
    axr(REG_RHI);
    chk(rdat, hi);
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 0;
    chk({18'h0, mi}, 32'h0);
    axw(REG_WLO, 32'h13121110);
    axw(REG_WHI, 32'h17161514);
    op(32'h0503);
    rd2(32'h0302, 32'h12111013, 32'h16151417);
    axw(REG_MODE, 32'h8);
    axr(REG_MODE);
    chk(rdat, 32'h8);
    op(32'h1);
    rd2(32'h0502, 32'h16171415, 32'h12131011);
    axw(REG_MODE, 32'h2);
    op(32'h1);
    axw(REG_WLO, 32'h23222120);
    op(32'h0713);
    chk({31'h0, bk}, 32'h0);
    repeat (12) @(posedge core_clk);
    chk({31'h0, bk}, 32'h1);
    rd2(32'h0602, 32'h21202322, 32'h0);
    axw(REG_MODE, 32'h1);
    op(32'h1);
    rd2(32'h060a, 32'h21202322, 32'h0);
    axw(REG_MODE, 32'h80);
    op(32'h1);
    chk({18'h0, mi}, 32'h0);
    rd2(32'h0402, 32'h23222120, 32'h13121110);
    axw(REG_CFG, 32'h2);
    rd2(32'h0002, 32'h13121110, 32'h23222120);
    axw(REG_CFG, 32'h0);
    axw(REG_MODE, 32'h100);
    axw(REG_CMD, 32'h4);
    repeat (6) @(posedge core_clk);
    chk({31'h0, lk}, 32'h0);
    chk({31'h0, rk}, 32'h0);
    op(32'h0);
    chk({31'h0, mi[MR_DLL_BIT]}, 32'h0);
    chk({31'h0, lk}, 32'h1);
    chk({31'h0, rk}, 32'h1);
    axr(8'h20);
    chk({30'h0, rsp}, 32'h2);
    axw(8'h22, 32'h0);
    chk({30'h0, rsp}, 32'h2);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ==== rtl/dbl_ctl_end.sv ====
// Controller end: AXI4-Lite register slave that issues mode sets and bursts.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module dbl_ctl_end
  import dbl_pkg::*;
#(
  parameter int DLLK_CYC = DLLK_CYC_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  dbl_if.ctl               bus,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  typedef enum logic [1:0] {CS_IDLE, CS_XFER, CS_DLL} dbl_state_t;

  dbl_state_t        state_r;
  logic              aw_hold_r;
  logic              w_hold_r;
  logic [7:0]        awaddr_r;
  logic [31:0]       wdata_r;
  logic [31:0]       wmask;
  logic              do_wr;
  logic [ADDR_W-1:0] mode_r;
  logic [ADDR_W-1:0] mode_set_r;
  logic [15:0]       cmd_r;
  logic              pend_r;
  logic [63:0]       wburst_r;
  logic [63:0]       rburst_r;
  logic [5:0]        al_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [2:0]        beat_r;
  logic              is_wr_op;
  logic              chop;
  logic              take;
  logic [ADDR_W-1:0] mode_fix;

  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr = aw_hold_r && w_hold_r;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign take = (state_r == CS_IDLE) && pend_r;
  assign is_wr_op = (cmd_r[2:0] == OP_WR);
  // Fixed chop forces four beats; in on-the-fly mode the command bit picks.
  assign chop = (mode_set_r[MR_BL_LSB +: 2] == BL_FIX4) ||
                ((mode_set_r[MR_BL_LSB +: 2] == BL_OTF) && cmd_r[3]);
  // Test mode is forced off; a recovery code below the minimum is raised to the top code.
  always_comb begin
    mode_fix = mode_r;
    mode_fix[MR_TM_BIT] = 1'b0;
    mode_fix[MR_DLL_BIT] = (cmd_r[2:0] == OP_DLL);
    if ((32'(wr_cycles(mode_r)) < WR_MIN_CYC) ||
        (32'(wr_cycles(mode_r) >> 1) < RTP_MIN_CYC) || ({mode_r[13], mode_r[11:9]} > 4'h8)) begin
      {mode_fix[13], mode_fix[11:9]} = 4'h8;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata & wmask;
      end
      if (do_wr) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r[7:5] == 3'h0 && awaddr_r[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; strobes were already folded into the held data.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_r   <= MODE_RST;
      wburst_r <= 64'h0;
      al_r     <= 6'h00;
      cmd_r    <= 16'h0000;
      pend_r   <= 1'b0;
    end else begin
      if (take) begin
        pend_r <= 1'b0;
      end
      if (do_wr) begin
        case (awaddr_r)
          REG_MODE: mode_r <= wdata_r[ADDR_W-1:0];
          REG_WLO:  wburst_r[31:0] <= wdata_r;
          REG_WHI:  wburst_r[63:32] <= wdata_r;
          REG_CFG:  al_r <= wdata_r[5:0];
          REG_CMD: begin
            if (!pend_r) begin
              cmd_r  <= wdata_r[15:0];
              pend_r <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        REG_MODE: s_axi_rdata <= 32'(mode_r);
        REG_CMD:  s_axi_rdata <= 32'(cmd_r);
        REG_WLO:  s_axi_rdata <= wburst_r[31:0];
        REG_WHI:  s_axi_rdata <= wburst_r[63:32];
        REG_RLO:  s_axi_rdata <= rburst_r[31:0];
        REG_RHI:  s_axi_rdata <= rburst_r[63:32];
        REG_STAT: s_axi_rdata <= {29'h0, state_r == CS_DLL, state_r != CS_IDLE, pend_r};
        REG_CFG:  s_axi_rdata <= 32'(al_r);
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign bus.added_delay = al_r[4:0];
  assign bus.crc_en = al_r[5];
  assign bus.dm = 1'b0;

  // Command sequencer; one command strobe cycle, then the burst slots.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r       <= CS_IDLE;
      {bus.ras_n, bus.cas_n, bus.we_n} <= CMD_NOP;
      bus.mr_sel    <= MR_SEL_FIRST;
      bus.addr      <= '0;
      bus.dq_ctl    <= '0;
      bus.dq_ctl_oe <= 1'b0;
      bus.crc       <= '0;
      mode_set_r    <= MODE_RST;
      cnt_r         <= '0;
      beat_r        <= 3'h0;
      rburst_r      <= 64'h0;
    end else begin
      {bus.ras_n, bus.cas_n, bus.we_n} <= CMD_NOP;
      case (state_r)
        CS_IDLE: begin
          if (take) begin
            beat_r <= 3'h0;
            case (cmd_r[2:0])
              OP_MRS, OP_DLL: begin
                {bus.ras_n, bus.cas_n, bus.we_n} <= CMD_MRS;
                bus.addr   <= mode_fix;
                mode_set_r <= mode_fix;
                cnt_r      <= CNT_W'(DLLK_CYC);
                state_r    <= (cmd_r[2:0] == OP_DLL) ? CS_DLL : CS_IDLE;
              end
              OP_RD, OP_WR: begin
                {bus.ras_n, bus.cas_n, bus.we_n} <= is_wr_op ? CMD_WR : CMD_RD;
                bus.addr <= '0;
                bus.addr[CHOP_BIT] <= !chop;
                bus.addr[AP_BIT] <= cmd_r[4];
                bus.addr[7:0] <= cmd_r[15:8];
                bus.crc <= wburst_r[7:0] ^ wburst_r[15:8] ^ wburst_r[23:16] ^ wburst_r[31:24] ^
                           (chop ? 8'h00 : wburst_r[39:32] ^ wburst_r[47:40] ^
                                           wburst_r[55:48] ^ wburst_r[63:56]);
                cnt_r   <= CNT_W'(al_r[4:0]) + CNT_W'(cl_cycles(mode_set_r)) + CNT_W'(1);
                state_r <= CS_XFER;
              end
              default: ;
            endcase
          end
        end
        CS_XFER: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
            if (cnt_r == CNT_W'(1) && is_wr_op) begin
              bus.dq_ctl    <= wburst_r[7:0];
              bus.dq_ctl_oe <= 1'b1;
            end
          end else begin
            beat_r <= beat_r + 3'h1;
            if (!is_wr_op) begin
              // Slots in which the device leaves its outputs off read back as zero.
              rburst_r[8*beat_r +: 8] <= bus.dq_dev_oe ? bus.dq_dev : 8'h00;
            end
            if (beat_r == 3'h7) begin
              bus.dq_ctl_oe <= 1'b0;
              state_r <= CS_IDLE;
            end else if (is_wr_op) begin
              bus.dq_ctl <= wburst_r[8*(beat_r + 3'h1) +: 8];
            end
          end
        end
        CS_DLL: begin
          if (cnt_r == '0) begin
            state_r <= CS_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: state_r <= CS_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== rtl/dbl_if.sv ====
// Command, address and data wires between the controller and the memory end.
`timescale 1ns/100ps
`default_nettype none
interface dbl_if;
  import dbl_pkg::*;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [2:0]        mr_sel;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0]   dq_ctl;
  logic              dq_ctl_oe;
  logic              dm;
  logic [DQ_W-1:0]   crc;
  logic              crc_en;
  logic [4:0]        added_delay;
  logic [DQ_W-1:0]   dq_dev;
  logic              dq_dev_oe;
  logic              dqs_dev_oe;

  modport ctl (output ras_n, cas_n, we_n, mr_sel, addr, dq_ctl, dq_ctl_oe, dm, crc,
               crc_en, added_delay, input dq_dev, dq_dev_oe, dqs_dev_oe);
  modport mem (input ras_n, cas_n, we_n, mr_sel, addr, dq_ctl, dq_ctl_oe, dm, crc,
               crc_en, added_delay, output dq_dev, dq_dev_oe, dqs_dev_oe);
endinterface
`default_nettype wire

// ==== rtl/dbl_mem_end.sv ====
// Memory end: first mode register, burst ordering, latencies and auto close timing.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Beat order follows length, type, start column.
// - Chop pin picks four or eight beats.
// - Sequential: rotate nibble, then other nibble.
// - Interleaved: column is start xor beat.
// - Chopped read: four beats, then outputs off.
// - Chopped write: bit 2 picks half, ascending.
// - Eight-beat write ascending, low bits ignored.
// - Fixed chop pulls write reference two clocks.
// - On-the-fly chop keeps eight-beat write reference.
// - First data column delay after internal read.
// - Total read delay is added plus column.
// - Controller keeps test mode bit cleared.
// - Controller programs recovery at least minimum.
// - Recovery plus precharge gates activate after write.
// - Mask plus checksum: check first, drop bad.
// - Controller programs read-to-close at least minimum.
// - Read-to-close plus precharge gates activate.
// - Loop reset bit clears itself.
// - Controller resets loop after enabling it.
// - Controller waits lock time after loop reset.
// - Mode set drives all three strobes low.
// - Length field: eight, on-the-fly, chop.
// - Bit 3 picks sequential or interleaved.
module dbl_mem_end
  import dbl_pkg::*;
#(
  parameter int COL_W    = 6,
  parameter int DLLK_CYC = DLLK_CYC_DEF
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  dbl_if.mem                 bus,
  output logic               bank_ready,
  output logic               read_ready,
  output logic               dll_locked,
  output logic [ADDR_W-1:0]  mode_image
);

  logic [DQ_W-1:0]   mem_r [2**COL_W];
  logic [ADDR_W-1:0] mode_r;
  logic [2:0]        cmd;
  logic              is_mrs;
  logic              is_rd;
  logic              is_wr;
  logic              chop_cmd;
  logic [6:0]        rl;
  logic [COL_W-1:0]  col;
  logic [CNT_W-1:0]  dll_cnt_r;
  logic [7:0]        ap_cnt_r;
  logic [7:0]        wtr_cnt_r;

  assign cmd = {bus.ras_n, bus.cas_n, bus.we_n};
  assign col = bus.addr[COL_W-1:0];
  assign is_mrs = (cmd == CMD_MRS) && (bus.mr_sel == MR_SEL_FIRST);
  // In test mode nothing is defined, so column commands are dropped.
  assign is_rd = (cmd == CMD_RD) && !mode_r[MR_TM_BIT];
  assign is_wr = (cmd == CMD_WR) && !mode_r[MR_TM_BIT];
  // The chop select pin is active low: low picks four beats.
  assign chop_cmd = (mode_r[MR_BL_LSB +: 2] == BL_FIX4) ||
                    ((mode_r[MR_BL_LSB +: 2] == BL_OTF) && !bus.addr[CHOP_BIT]);
  assign rl = 7'(bus.added_delay) + 7'(cl_cycles(mode_r));
  assign mode_image = mode_r;
  assign dll_locked = (dll_cnt_r == '0);
  assign bank_ready = (ap_cnt_r == 8'h00);
  assign read_ready = (wtr_cnt_r == 8'h00) && dll_locked;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_r <= MODE_RST;
    end else if (is_mrs) begin
      mode_r <= bus.addr;
    end else if (mode_r[MR_DLL_BIT]) begin
      mode_r[MR_DLL_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dll_cnt_r <= '0;
    end else if (mode_r[MR_DLL_BIT]) begin
      dll_cnt_r <= CNT_W'(DLLK_CYC);
    end else if (dll_cnt_r != '0) begin
      dll_cnt_r <= dll_cnt_r - 1'b1;
    end
  end

  // Read path: one burst in flight; settings are captured with the command.
  logic             rd_pend_r;
  logic             rd_act_r;
  logic             rd_chop_r;
  logic             rd_bt_r;
  logic [6:0]       rd_dly_r;
  logic [2:0]       rd_start_r;
  logic [2:0]       rd_beat_r;
  logic [COL_W-1:0] rd_base_r;
  logic             rd_go;
  logic             rd_show;
  logic [2:0]       rd_idx;
  logic             rd_take;

  assign rd_take = is_rd && !rd_pend_r && !rd_act_r;
  assign rd_go = rd_pend_r && (rd_dly_r == 7'h00);
  assign rd_show = rd_go || (rd_act_r && (rd_beat_r != 3'h7));
  assign rd_idx = rd_go ? 3'h0 : rd_beat_r + 3'h1;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_pend_r  <= 1'b0;
      rd_act_r   <= 1'b0;
      rd_chop_r  <= 1'b0;
      rd_bt_r    <= 1'b0;
      rd_dly_r   <= 7'h00;
      rd_start_r <= 3'h0;
      rd_beat_r  <= 3'h0;
      rd_base_r  <= '0;
    end else if (rd_take) begin
      rd_pend_r  <= 1'b1;
      rd_dly_r   <= rl - 7'h01;
      rd_start_r <= col[2:0];
      rd_base_r  <= {col[COL_W-1:3], 3'h0};
      rd_bt_r    <= mode_r[MR_BT_BIT];
      rd_chop_r  <= chop_cmd;
    end else if (rd_go) begin
      rd_pend_r <= 1'b0;
      rd_act_r  <= 1'b1;
      rd_beat_r <= 3'h0;
    end else if (rd_pend_r) begin
      rd_dly_r <= rd_dly_r - 7'h01;
    end else if (rd_act_r) begin
      rd_beat_r <= rd_beat_r + 3'h1;
      rd_act_r  <= (rd_beat_r != 3'h7);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus.dq_dev     <= '0;
      bus.dq_dev_oe  <= 1'b0;
      bus.dqs_dev_oe <= 1'b0;
    end else if (rd_show) begin
      bus.dq_dev     <= mem_r[rd_base_r | COL_W'(beat_col(rd_start_r, rd_idx, rd_bt_r))];
      bus.dq_dev_oe  <= !rd_chop_r || !rd_idx[2];
      bus.dqs_dev_oe <= !rd_chop_r || !rd_idx[2];
    end else begin
      bus.dq_dev_oe  <= 1'b0;
      bus.dqs_dev_oe <= 1'b0;
    end
  end

  // Write path: beats land in a burst buffer and commit one clock after the last slot.
  logic             wr_pend_r;
  logic             wr_act_r;
  logic             wr_chop_r;
  logic             wr_fix4_r;
  logic             wr_ap_r;
  logic             wr_crc_r;
  logic [6:0]       wr_dly_r;
  logic [2:0]       wr_beat_r;
  logic [COL_W-1:0] wr_base_r;
  logic [DQ_W-1:0]  wbuf_r [8];
  logic [7:0]       wkeep_r;
  logic [DQ_W-1:0]  wsum_r;
  logic             crc_ok_r;
  logic             commit_r;
  logic             beat_used;
  logic             wr_ref;

  assign beat_used = !wr_chop_r || !wr_beat_r[2];
  assign wr_ref = wr_act_r &&
                  (wr_beat_r == (wr_fix4_r ? 3'(7 - CHOP_PULL_CYC) : 3'h7));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_act_r  <= 1'b0;
      wr_chop_r <= 1'b0;
      wr_fix4_r <= 1'b0;
      wr_ap_r   <= 1'b0;
      wr_crc_r  <= 1'b0;
      wr_dly_r  <= 7'h00;
      wr_beat_r <= 3'h0;
      wr_base_r <= '0;
      wkeep_r   <= 8'h00;
      wsum_r    <= '0;
      crc_ok_r  <= 1'b0;
      commit_r  <= 1'b0;
    end else begin
      commit_r <= wr_act_r && (wr_beat_r == 3'h7);
      if (is_wr && !wr_pend_r && !wr_act_r) begin
        wr_pend_r <= 1'b1;
        wr_dly_r  <= rl - 7'h01;
        wr_chop_r <= chop_cmd;
        wr_fix4_r <= (mode_r[MR_BL_LSB +: 2] == BL_FIX4);
        wr_ap_r   <= bus.addr[AP_BIT];
        wr_crc_r  <= bus.crc_en;
        // Chopped writes keep column bit 2; all other low bits are ignored.
        wr_base_r <= chop_cmd ? {col[COL_W-1:2], 2'h0} : {col[COL_W-1:3], 3'h0};
      end else if (wr_pend_r) begin
        if (wr_dly_r == 7'h00) begin
          wr_pend_r <= 1'b0;
          wr_act_r  <= 1'b1;
          wr_beat_r <= 3'h0;
          wsum_r    <= '0;
        end else begin
          wr_dly_r <= wr_dly_r - 7'h01;
        end
      end else if (wr_act_r) begin
        wkeep_r[wr_beat_r] <= beat_used && !bus.dm;
        if (beat_used) begin
          wsum_r <= wsum_r ^ bus.dq_ctl;
        end
        wr_beat_r <= wr_beat_r + 3'h1;
        if (wr_beat_r == 3'h7) begin
          wr_act_r <= 1'b0;
          crc_ok_r <= !wr_crc_r ||
                      ((wsum_r ^ (beat_used ? bus.dq_ctl : '0)) == bus.crc);
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_act_r) begin
      wbuf_r[wr_beat_r] <= bus.dq_ctl;
    end
  end

  // A failed checksum drops the whole burst before it reaches the array.
  always_ff @(posedge core_clk) begin
    if (commit_r && crc_ok_r) begin
      for (int i = 0; i < 8; i++) begin
        if (wkeep_r[i]) begin
          mem_r[wr_base_r | COL_W'(i)] <= wbuf_r[i];
        end
      end
    end
  end

  // Auto close and write-to-read holds.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ap_cnt_r <= 8'h00;
    end else if (wr_ref && wr_ap_r) begin
      ap_cnt_r <= 8'(wr_cycles(mode_r)) + 8'(RP_CYC) +
                  (wr_crc_r ? 8'(CRC_EXTRA_CYC) : 8'h00);
    end else if (rd_take && bus.addr[AP_BIT]) begin
      ap_cnt_r <= 8'(bus.added_delay) + 8'(wr_cycles(mode_r) >> 1) + 8'(RP_CYC);
    end else if (ap_cnt_r != 8'h00) begin
      ap_cnt_r <= ap_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wtr_cnt_r <= 8'h00;
    end else if (wr_ref) begin
      wtr_cnt_r <= 8'(WTR_CYC) + (wr_crc_r ? 8'(CRC_EXTRA_CYC) : 8'h00);
    end else if (wtr_cnt_r != 8'h00) begin
      wtr_cnt_r <= wtr_cnt_r - 8'h01;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/dbl_pkg.sv ====
// Shared constants, commands and decode functions for the burst and latency link.
package dbl_pkg;

  localparam int DQ_W   = 8;
  localparam int ADDR_W = 14;
  localparam int CNT_W  = 16;

  // Mode image field positions, then the auto close and chop bits of the column address.
  localparam int MR_BL_LSB  = 0;
  localparam int MR_BT_BIT  = 3;
  localparam int MR_TM_BIT  = 7;
  localparam int MR_DLL_BIT = 8;
  localparam int AP_BIT     = 10;
  localparam int CHOP_BIT   = 12;
  localparam logic [ADDR_W-1:0] MODE_RST = 14'h0000;
  localparam logic [2:0] MR_SEL_FIRST = 3'h0;

  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;

  // Row, column, write-enable strobes in that order.
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // Timing, in picoseconds, and derived clock counts at 100 MHz.
  localparam int CLK_PS     = 10000;
  localparam int T_WR_PS    = 15000;
  localparam int T_RTP_PS   = 7500;
  localparam int T_RP_PS    = 13750;
  localparam int T_WTR_PS   = 7500;
  localparam int WR_MIN_CYC  = (T_WR_PS + CLK_PS - 1) / CLK_PS;
  localparam int RTP_MIN_CYC = (T_RTP_PS + CLK_PS - 1) / CLK_PS;
  localparam int RP_CYC      = (T_RP_PS + CLK_PS - 1) / CLK_PS;
  localparam int WTR_CYC     = (T_WTR_PS + CLK_PS - 1) / CLK_PS;
  localparam int DLLK_CYC_DEF = 768;
  localparam int CHOP_PULL_CYC = 2;
  localparam int CRC_EXTRA_CYC = 2;

  // AXI register offsets and command register opcodes.
  localparam logic [7:0] REG_MODE  = 8'h00;
  localparam logic [7:0] REG_CMD   = 8'h04;
  localparam logic [7:0] REG_WLO   = 8'h08;
  localparam logic [7:0] REG_WHI   = 8'h0c;
  localparam logic [7:0] REG_RLO   = 8'h10;
  localparam logic [7:0] REG_RHI   = 8'h14;
  localparam logic [7:0] REG_STAT  = 8'h18;
  localparam logic [7:0] REG_CFG   = 8'h1c;
  localparam logic [2:0] OP_MRS = 3'h1;
  localparam logic [2:0] OP_RD  = 3'h2;
  localparam logic [2:0] OP_WR  = 3'h3;
  localparam logic [2:0] OP_DLL = 3'h4;

  function automatic logic [5:0] cl_cycles(input logic [ADDR_W-1:0] m);
    case ({m[12], m[6:4], m[2]})
      5'h00: cl_cycles = 6'h09;   5'h01: cl_cycles = 6'h0a;
      5'h02: cl_cycles = 6'h0b;   5'h03: cl_cycles = 6'h0c;
      5'h04: cl_cycles = 6'h0d;   5'h05: cl_cycles = 6'h0e;
      5'h06: cl_cycles = 6'h0f;   5'h07: cl_cycles = 6'h10;
      5'h08: cl_cycles = 6'h12;   5'h09: cl_cycles = 6'h14;
      5'h0a: cl_cycles = 6'h16;   5'h0b: cl_cycles = 6'h18;
      5'h0c: cl_cycles = 6'h17;   5'h0d: cl_cycles = 6'h11;
      5'h0e: cl_cycles = 6'h13;   5'h0f: cl_cycles = 6'h15;
      5'h10: cl_cycles = 6'h19;   5'h11: cl_cycles = 6'h1a;
      5'h12: cl_cycles = 6'h1b;   5'h13: cl_cycles = 6'h1c;
      5'h14: cl_cycles = 6'h1d;   5'h15: cl_cycles = 6'h1e;
      5'h16: cl_cycles = 6'h1f;   5'h17: cl_cycles = 6'h20;
      default: cl_cycles = 6'h09;
    endcase
  endfunction

  // Write recovery clocks; the read-to-close value is always half of it.
  function automatic logic [4:0] wr_cycles(input logic [ADDR_W-1:0] m);
    case ({m[13], m[11:9]})
      4'h0: wr_cycles = 5'h0a;   4'h1: wr_cycles = 5'h0c;
      4'h2: wr_cycles = 5'h0e;   4'h3: wr_cycles = 5'h10;
      4'h4: wr_cycles = 5'h12;   4'h5: wr_cycles = 5'h14;
      4'h6: wr_cycles = 5'h18;   4'h7: wr_cycles = 5'h16;
      default: wr_cycles = 5'h1a;
    endcase
  endfunction

  function automatic logic [2:0] beat_col(input logic [2:0] s, input logic [2:0] i,
                                          input logic il);
    beat_col = il ? (s ^ i) : {s[2] ^ i[2], s[1:0] + i[1:0]};
  endfunction

endpackage
